// ==== design/antenna_driver_control.v ====
// antenna driver control: carrier generation, driver registers, two output drivers
// assumes crystal_clock is an asynchronous pin much slower than sys_clk in this model,
// and tx_envelope comes from framing logic on sys_clk
// assumes the register port never raises both strobes in one cycle
// assumes P_WIDTH below 8 and N_WIDTH of 4, matching the register fields
// assumes tx_envelope is high while the carrier is meant to be on
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`include "antenna_driver_control_regs.vh"

module antenna_driver_control #(
   parameter P_WIDTH = 6,
   parameter N_WIDTH = 4
) (
   input  wire               sys_clk,
   input  wire               rst,
   input  wire [3:0]         reg_addr,
   input  wire [7:0]         reg_wdata,
   input  wire               reg_write,
   input  wire               reg_read,
   output wire [7:0]         reg_rdata,
   input  wire               crystal_clock,
   input  wire               tx_envelope,
   output wire               carrier_clock,
   output wire               carrier_clock_inverted,
   output wire               antenna_out_a,
   output wire               antenna_out_b,
   output wire [P_WIDTH-1:0] pmos_array_setting_a,
   output wire [N_WIDTH-1:0] nmos_array_setting_a,
   output wire [P_WIDTH-1:0] pmos_array_setting_b,
   output wire [N_WIDTH-1:0] nmos_array_setting_b
);

   // pad width of the p registers; a zero-width pad is not legal,
   // so P_WIDTH must stay below 8
   localparam P_PAD = 8 - P_WIDTH;

   // ---- register file ----
   reg  [7:0] driver_control_reg;
   reg  [7:0] p_side_wave_conductance_reg;
   reg  [7:0] p_side_mod_conductance_reg;
   reg  [7:0] n_side_conductance_reg;
   reg  [7:0] rdata_reg;
   reg  [7:0] rdata_next;
   reg  [7:0] status_word;

   // ---- write decode ----
   wire [7:0] p_write_value;
   wire       write_control;
   wire       write_p_wave;
   wire       write_p_mod;
   wire       write_n_side;

   // ---- carrier generation ----
   wire crystal_level;
   reg  crystal_prev_reg;
   reg  carrier_reg;
   reg  carrier_inv_reg;
   wire crystal_rise;
   wire carrier_rise;

   // ---- driver state seen by status ----
   wire first_active;
   wire second_active;
   wire first_modulating;
   wire second_modulating;

   // decoded control bits of the first driver
   wire first_driver_enable    = driver_control_reg[`CTRL_FIRST_ENABLE];
   wire first_invert_when_on   = driver_control_reg[`CTRL_FIRST_INV_ON];

   // decoded control bits of the second driver
   wire second_driver_enable   = driver_control_reg[`CTRL_SECOND_ENABLE];
   wire second_unmodulated     = driver_control_reg[`CTRL_SECOND_UNMOD];
   wire second_invert_when_on  = driver_control_reg[`CTRL_SECOND_INV_ON];

   // full ASK is shared; each driver applies it only while modulating
   wire force_full_ask         = driver_control_reg[`CTRL_FORCE_FULL_ASK];

   // the invert-when-off bits are stored and read back; in these modes they do not
   // change the pin, which rests low or follows the carrier regardless

   // conductance values, shared by both drivers
   wire [P_WIDTH-1:0] pmos_wave_value;
   wire [P_WIDTH-1:0] pmos_mod_value;
   wire [N_WIDTH-1:0] nmos_wave_value;
   wire [N_WIDTH-1:0] nmos_mod_value;

   // p side from its two registers
   assign pmos_wave_value = p_side_wave_conductance_reg[P_WIDTH-1:0];
   assign pmos_mod_value  = p_side_mod_conductance_reg[P_WIDTH-1:0];

   // n side from two fields of one register
   assign nmos_wave_value = n_side_conductance_reg[`N_WAVE_MSB:`N_WAVE_LSB];
   assign nmos_mod_value  = n_side_conductance_reg[`N_MOD_MSB:`N_MOD_LSB];

   // write strobes decoded once; status and unmapped addresses take no write,
   // so software can never disturb the live status bits
   assign write_control = reg_write & (reg_addr == `ADDR_DRIVER_CONTROL);
   assign write_p_wave  = reg_write & (reg_addr == `ADDR_P_WAVE);
   assign write_p_mod   = reg_write & (reg_addr == `ADDR_P_MOD);
   assign write_n_side  = reg_write & (reg_addr == `ADDR_N_SIDE);

   // only the low bits reach the p array, so the rest is stored as zero
   assign p_write_value = {{P_PAD{1'b0}}, reg_wdata[P_WIDTH-1:0]};

   // control register; the drivers pick new bits up at the next carrier rise
   always @(posedge sys_clk) begin
      if (rst) begin
         driver_control_reg <= `RST_DRIVER_CONTROL;
      end else if (write_control) begin
         driver_control_reg <= reg_wdata;
      end
   end

   // p-side continuous-wave conductance
   always @(posedge sys_clk) begin
      if (rst) begin
         p_side_wave_conductance_reg <= `RST_P_WAVE;
      end else if (write_p_wave) begin
         p_side_wave_conductance_reg <= p_write_value;
      end
   end

   // p-side modulation conductance
   always @(posedge sys_clk) begin
      if (rst) begin
         p_side_mod_conductance_reg <= `RST_P_MOD;
      end else if (write_p_mod) begin
         p_side_mod_conductance_reg <= p_write_value;
      end
   end

   // n-side register holds both fields; they are split where they are used
   always @(posedge sys_clk) begin
      if (rst) begin
         n_side_conductance_reg <= `RST_N_SIDE;
      end else if (write_n_side) begin
         n_side_conductance_reg[`N_WAVE_MSB:`N_WAVE_LSB] <= reg_wdata[`N_WAVE_MSB:`N_WAVE_LSB];
         n_side_conductance_reg[`N_MOD_MSB:`N_MOD_LSB]   <= reg_wdata[`N_MOD_MSB:`N_MOD_LSB];
      end
   end

   // status shows live carrier level and what each driver currently applies
   always @* begin
      // bits above the second driver's flag read as zero
      status_word                      = 8'h00;
      status_word[`STAT_CARRIER]       = carrier_reg;
      status_word[`STAT_FIRST_ACTIVE]  = first_active;
      status_word[`STAT_SECOND_ACTIVE] = second_active;
      status_word[`STAT_FIRST_MOD]     = first_modulating;
      status_word[`STAT_SECOND_MOD]    = second_modulating;
   end

   // read mux; unmapped addresses read as zero
   always @* begin
      rdata_next = 8'h00;
      case (reg_addr)
         `ADDR_DRIVER_CONTROL: begin
            rdata_next = driver_control_reg;
         end
         `ADDR_P_WAVE: begin
            rdata_next = p_side_wave_conductance_reg;
         end
         `ADDR_P_MOD: begin
            rdata_next = p_side_mod_conductance_reg;
         end
         `ADDR_N_SIDE: begin
            rdata_next = n_side_conductance_reg;
         end
         `ADDR_STATUS: begin
            rdata_next = status_word;
         end
         default: begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always @(posedge sys_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_read) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // read data leaves straight from its flop
   assign reg_rdata = rdata_reg;

   // crystal pin enters through the filter before any edge is looked for
   pin_input_filter crystal_filter (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (crystal_clock),
      .level   (crystal_level)
   );

   // previous filtered level, for finding its rising edge
   always @(posedge sys_clk) begin
      if (rst) begin
         crystal_prev_reg <= 1'b0;
      end else begin
         crystal_prev_reg <= crystal_level;
      end
   end

   assign crystal_rise = crystal_level & ~crystal_prev_reg;

   // toggling on every crystal rise halves the crystal frequency
   always @(posedge sys_clk) begin
      if (rst) begin
         carrier_reg <= 1'b0;
      end else if (crystal_rise) begin
         carrier_reg <= ~carrier_reg;
      end
   end

   // the inverted copy is its own flop, so it never lags the carrier through a gate
   always @(posedge sys_clk) begin
      if (rst) begin
         carrier_inv_reg <= 1'b1;
      end else if (crystal_rise) begin
         carrier_inv_reg <= carrier_reg;
      end
   end

   // a carrier rise is the moment the carrier leaves its low half;
   // the drivers latch here, so no setting changes inside a high half
   assign carrier_rise = crystal_rise & ~carrier_reg;

   // both carrier copies leave straight from flops
   assign carrier_clock          = carrier_reg;
   assign carrier_clock_inverted = carrier_inv_reg;

   // per driver, at each carrier rise:
   //   disabled           -> pin low, both arrays off
   //   unmodulated        -> carrier or inverse, wave conductances
   //   envelope high      -> carrier or inverse, wave conductances
   //   envelope low       -> carrier or inverse, modulation conductances
   //   envelope low + ASK -> pin low, modulation conductances
   // unmodulated ignores both the envelope and the full ASK bit
   // the invert-when-off bits change nothing in any of these rows
   // both drivers take the very same register values, whichever is enabled
   antenna_output_select #(
      .P_WIDTH (P_WIDTH),
      .N_WIDTH (N_WIDTH)
   ) first_driver (
      // carrier timing, then this driver's settings
      .sys_clk            (sys_clk),
      .rst                (rst),
      .carrier_rise       (carrier_rise),
      .carrier            (carrier_reg),
      .enable             (first_driver_enable),
      .force_full_ask     (force_full_ask),
      .invert_when_on     (first_invert_when_on),
      .unmodulated        (1'b0),
      .envelope           (tx_envelope),
      // shared conductance values
      .pmos_wave_value    (pmos_wave_value),
      .pmos_mod_value     (pmos_mod_value),
      .nmos_wave_value    (nmos_wave_value),
      .nmos_mod_value     (nmos_mod_value),
      // driver a outputs
      .antenna_out        (antenna_out_a),
      .pmos_array_setting (pmos_array_setting_a),
      .nmos_array_setting (nmos_array_setting_a),
      .active             (first_active),
      .modulating         (first_modulating)
   );

   // the second driver alone may run as an unmodulated carrier
   antenna_output_select #(
      .P_WIDTH (P_WIDTH),
      .N_WIDTH (N_WIDTH)
   ) second_driver (
      // carrier timing, then this driver's settings
      .sys_clk            (sys_clk),
      .rst                (rst),
      .carrier_rise       (carrier_rise),
      .carrier            (carrier_reg),
      .enable             (second_driver_enable),
      .force_full_ask     (force_full_ask),
      .invert_when_on     (second_invert_when_on),
      .unmodulated        (second_unmodulated),
      .envelope           (tx_envelope),
      // shared conductance values
      .pmos_wave_value    (pmos_wave_value),
      .pmos_mod_value     (pmos_mod_value),
      .nmos_wave_value    (nmos_wave_value),
      .nmos_mod_value     (nmos_mod_value),
      // driver b outputs
      .antenna_out        (antenna_out_b),
      .pmos_array_setting (pmos_array_setting_b),
      .nmos_array_setting (nmos_array_setting_b),
      .active             (second_active),
      .modulating         (second_modulating)
   );

endmodule

// ==== design/antenna_driver_control_regs.vh ====
// constants for the antenna driver control block: register map, fields, reset values
// assumes an 8-bit register port with a 4-bit word address, one register per address
`ifndef ANTENNA_DRIVER_CONTROL_REGS_VH
`define ANTENNA_DRIVER_CONTROL_REGS_VH

// register word addresses
`define ADDR_DRIVER_CONTROL     4'h0
`define ADDR_P_WAVE             4'h1
`define ADDR_P_MOD              4'h2
`define ADDR_N_SIDE             4'h3
`define ADDR_STATUS             4'h4

// driver_control_reg bit positions
`define CTRL_FIRST_ENABLE       0
`define CTRL_SECOND_ENABLE      1
`define CTRL_SECOND_UNMOD       2
`define CTRL_FIRST_INV_OFF      3
`define CTRL_FIRST_INV_ON       4
`define CTRL_SECOND_INV_OFF     5
`define CTRL_SECOND_INV_ON      6
`define CTRL_FORCE_FULL_ASK     7

// n_side_conductance field positions
`define N_WAVE_MSB              7
`define N_WAVE_LSB              4
`define N_MOD_MSB               3
`define N_MOD_LSB               0

// status register bit positions
`define STAT_CARRIER            0
`define STAT_FIRST_ACTIVE       1
`define STAT_SECOND_ACTIVE      2
`define STAT_FIRST_MOD          3
`define STAT_SECOND_MOD         4

// reset values
`define RST_DRIVER_CONTROL      8'h00
`define RST_P_WAVE              8'h3f
`define RST_P_MOD               8'h20
`define RST_N_SIDE              8'h88

// conductance value driven by a switched-off driver
`define COND_OFF_BIT            1'b0

`endif

// ==== design/antenna_output_select.v ====
// output selection and conductance choice for one antenna driver
// assumes carrier_rise is a one-cycle pulse when the carrier goes high
`timescale 1ns/10ps
`include "antenna_driver_control_regs.vh"

module antenna_output_select #(
   parameter P_WIDTH = 6,
   parameter N_WIDTH = 4
) (
   input  wire               sys_clk,
   input  wire               rst,
   input  wire               carrier_rise,
   input  wire               carrier,
   input  wire               enable,
   input  wire               force_full_ask,
   input  wire               invert_when_on,
   input  wire               unmodulated,
   input  wire               envelope,
   input  wire [P_WIDTH-1:0] pmos_wave_value,
   input  wire [P_WIDTH-1:0] pmos_mod_value,
   input  wire [N_WIDTH-1:0] nmos_wave_value,
   input  wire [N_WIDTH-1:0] nmos_mod_value,
   output wire               antenna_out,
   output wire [P_WIDTH-1:0] pmos_array_setting,
   output wire [N_WIDTH-1:0] nmos_array_setting,
   output wire               active,
   output wire               modulating
);

   reg               en_reg;
   reg               inv_reg;
   reg               low_reg;
   reg               use_mod_reg;
   reg               pin_reg;
   reg [P_WIDTH-1:0] p_reg;
   reg [N_WIDTH-1:0] n_reg;

   // unmodulated drivers never see the envelope or the full ASK bit
   wire mod_now = enable & ~unmodulated & ~envelope;
   wire low_now = mod_now & force_full_ask;

   // settings are taken only at a carrier rise so the pin never glitches
   always @(posedge sys_clk) begin
      if (rst) begin
         en_reg      <= 1'b0;
         inv_reg     <= 1'b0;
         low_reg     <= 1'b0;
         use_mod_reg <= 1'b0;
         p_reg       <= {P_WIDTH{`COND_OFF_BIT}};
         n_reg       <= {N_WIDTH{`COND_OFF_BIT}};
      end else if (carrier_rise) begin
         en_reg      <= enable;
         inv_reg     <= invert_when_on;
         low_reg     <= low_now;
         use_mod_reg <= mod_now;
         if (!enable) begin
            p_reg <= {P_WIDTH{`COND_OFF_BIT}};
            n_reg <= {N_WIDTH{`COND_OFF_BIT}};
         end else if (mod_now) begin
            p_reg <= pmos_mod_value;
            n_reg <= nmos_mod_value;
         end else begin
            p_reg <= pmos_wave_value;
            n_reg <= nmos_wave_value;
         end
      end
   end

   // pin follows the carrier one cycle late; a disabled pin rests low
   always @(posedge sys_clk) begin
      if (rst) begin
         pin_reg <= 1'b0;
      end else begin
         pin_reg <= en_reg & ~low_reg & (carrier ^ inv_reg);
      end
   end

   assign antenna_out        = pin_reg;
   assign pmos_array_setting = p_reg;
   assign nmos_array_setting = n_reg;
   assign active             = en_reg;
   assign modulating         = use_mod_reg;

endmodule

// ==== design/pin_input_filter.v ====
// three-stage synchroniser with agreement filter for one asynchronous pin
// assumes the pin is slow compared with sys_clk; shorter pulses may be missed
`timescale 1ns/10ps

module pin_input_filter (
   input  wire sys_clk,
   input  wire rst,
   input  wire pin_in,
   output wire level
);

   reg stage1_reg;
   reg stage2_reg;
   reg stage3_reg;
   reg level_reg;

   // stage1 feeds only stage2; the level moves once stage2 and stage3 agree
   always @(posedge sys_clk) begin
      if (rst) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         level_reg  <= 1'b0;
      end else begin
         stage1_reg <= pin_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            level_reg <= stage3_reg;
         end
      end
   end

   assign level = level_reg;

endmodule

// ==== tb/antenna_coil_model.sv ====
// stand-in for the matching network and coil: counts rising drive edges per coil end
// assumes the pins change only on sys_clk edges
`timescale 1ns/10ps
module antenna_coil_model (
   input  wire logic       sys_clk,
   input  wire logic       drive_a,
   input  wire logic       drive_b,
   output logic      [7:0] edges_a,
   output logic      [7:0] edges_b
);
   logic       a_q = 1'b0;
   logic       b_q = 1'b0;
   logic [7:0] count_a = 8'h00;
   logic [7:0] count_b = 8'h00;

   // one driver per counter: the counts live here and the ports only show them
   assign edges_a = count_a;
   assign edges_b = count_b;

   // a passive tank only shows energy while driven by edges; a steady pin gives none
   always @(posedge sys_clk) begin
      a_q <= drive_a;
      b_q <= drive_b;
      if (drive_a && !a_q) count_a <= count_a + 8'h01;
      if (drive_b && !b_q) count_b <= count_b + 8'h01;
   end
endmodule

// ==== tb/antenna_driver_control_assertions.sv ====
// checker for the antenna driver control block, bound to its ports
// assumes crystal_clock has a period of at least 8 sys_clk cycles
`timescale 1ns/10ps
module antenna_driver_control_assertions #(
   parameter P_WIDTH = 6,
   parameter N_WIDTH = 4
) (
   input wire logic               sys_clk,
   input wire logic               rst,
   input wire logic [3:0]         reg_addr,
   input wire logic [7:0]         reg_wdata,
   input wire logic               reg_write,
   input wire logic               tx_envelope,
   input wire logic               carrier_clock,
   input wire logic               carrier_clock_inverted,
   input wire logic               antenna_out_a,
   input wire logic [P_WIDTH-1:0] pmos_array_setting_a,
   input wire logic [N_WIDTH-1:0] nmos_array_setting_a,
   input wire logic [P_WIDTH-1:0] pmos_array_setting_b,
   input wire logic [N_WIDTH-1:0] nmos_array_setting_b
);
   logic [7:0] ctl_reg;
   logic [7:0] pw_reg;
   logic [7:0] pm_reg;
   logic [7:0] n_reg;

   // shadow copy of the driver registers, rebuilt from the write port
   always @(posedge sys_clk) begin
      if (rst) begin
         ctl_reg <= 8'h00;
         pw_reg <= 8'h3f;
         pm_reg <= 8'h20;
         n_reg <= 8'h88;
      end else if (reg_write) begin
         if (reg_addr == 4'h0) ctl_reg <= reg_wdata;
         if (reg_addr == 4'h1) pw_reg <= reg_wdata;
         if (reg_addr == 4'h2) pm_reg <= reg_wdata;
         if (reg_addr == 4'h3) n_reg <= reg_wdata;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // settings latch on the edge where the carrier rises, so compare with the cycle before
   chk_off_a: assert property (
      $rose(carrier_clock) && !$past(ctl_reg[0])
      |-> pmos_array_setting_a == '0 && nmos_array_setting_a == '0)
      else $error("driver a conductance not off");
   chk_off_b: assert property (
      $rose(carrier_clock) && !$past(ctl_reg[1])
      |-> pmos_array_setting_b == '0 && nmos_array_setting_b == '0)
      else $error("driver b conductance not off");
   chk_mod_a: assert property (
      $rose(carrier_clock) && $past(ctl_reg[0]) && !$past(tx_envelope)
      |-> pmos_array_setting_a == $past(pm_reg[P_WIDTH-1:0])
      && nmos_array_setting_a == $past(n_reg[3:0]))
      else $error("driver a modulation conductance wrong");
   chk_wave_a: assert property (
      $rose(carrier_clock) && $past(ctl_reg[0]) && $past(tx_envelope)
      |-> pmos_array_setting_a == $past(pw_reg[P_WIDTH-1:0])
      && nmos_array_setting_a == $past(n_reg[7:4]))
      else $error("driver a wave conductance wrong");
   chk_unmod_b: assert property (
      $rose(carrier_clock) && $past(ctl_reg[1]) && $past(ctl_reg[2])
      |-> pmos_array_setting_b == $past(pw_reg[P_WIDTH-1:0])
      && nmos_array_setting_b == $past(n_reg[7:4]))
      else $error("unmodulated driver b conductance wrong");
   chk_inverse_pair: assert property (
      carrier_clock_inverted != carrier_clock)
      else $error("inverted carrier equals carrier");
   chk_carrier_hold: assert property (
      $rose(carrier_clock) |=> carrier_clock [*3])
      else $error("carrier high phase too short");
   chk_cond_stands: assert property (
      !$stable(pmos_array_setting_b) |-> $rose(carrier_clock))
      else $error("conductance changed away from a carrier rise");
   chk_forced_low: assert property (
      $rose(carrier_clock) && $past(ctl_reg[0]) && $past(ctl_reg[7]) && !$past(tx_envelope)
      |=> !antenna_out_a [*4])
      else $error("forced low pin a not low");
   chk_pin_follows: assert property (
      $rose(carrier_clock) && $past(ctl_reg[0]) && !$past(ctl_reg[7]) && !$past(ctl_reg[4])
      |=> antenna_out_a [*4])
      else $error("pin a not following carrier");

   cov_mod: cover property ($rose(carrier_clock) && $past(ctl_reg[0]) && !$past(tx_envelope));
   cov_unmod: cover property ($rose(carrier_clock) && $past(ctl_reg[1]) && $past(ctl_reg[2]));
   cov_forced: cover property ($rose(carrier_clock) && $past(ctl_reg[7]) && !$past(tx_envelope));
endmodule

bind antenna_driver_control antenna_driver_control_assertions #(
   .P_WIDTH(P_WIDTH),
   .N_WIDTH(N_WIDTH)
) u_chk (
   .sys_clk               (sys_clk),
   .rst                   (rst),
   .reg_addr              (reg_addr),
   .reg_wdata             (reg_wdata),
   .reg_write             (reg_write),
   .tx_envelope           (tx_envelope),
   .carrier_clock         (carrier_clock),
   .carrier_clock_inverted(carrier_clock_inverted),
   .antenna_out_a         (antenna_out_a),
   .pmos_array_setting_a  (pmos_array_setting_a),
   .nmos_array_setting_a  (nmos_array_setting_a),
   .pmos_array_setting_b  (pmos_array_setting_b),
   .nmos_array_setting_b  (nmos_array_setting_b)
);

// ==== tb/antenna_driver_control_tb_top.sv ====
// testbench for the antenna driver control block
// assumes default widths: 6-bit pmos and 4-bit nmos settings
`timescale 1ns/10ps
module antenna_driver_control_tb_top;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic       crystal_clock = 1'b0;
   logic       tx_envelope = 1'b0;
   wire  [7:0] reg_rdata;
   wire        carrier, carrier_n, pin_a, pin_b;
   wire  [5:0] pmos_a, pmos_b;
   wire  [3:0] nmos_a, nmos_b;
   wire  [7:0] edges_a, edges_b;
   int         bad_count = 0;
   int         checks = 0;
   int         cycles = 0;
   logic [7:0] cfgs [7] = '{8'h00, 8'h11, 8'h83, 8'hd3, 8'h86, 8'hc6, 8'h2b};

   antenna_driver_control i_dut (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .crystal_clock(crystal_clock), .tx_envelope(tx_envelope),
      .carrier_clock(carrier), .carrier_clock_inverted(carrier_n),
      .antenna_out_a(pin_a), .antenna_out_b(pin_b),
      .pmos_array_setting_a(pmos_a), .nmos_array_setting_a(nmos_a),
      .pmos_array_setting_b(pmos_b), .nmos_array_setting_b(nmos_b));

   antenna_coil_model i_coil (
      .sys_clk(sys_clk), .drive_a(pin_a), .drive_b(pin_b),
      .edges_a(edges_a), .edges_b(edges_b));

   initial forever #25 sys_clk = ~sys_clk;

   // crystal at one eighth of sys_clk, slow enough for the pin filter
   initial forever begin
      repeat (4) @(posedge sys_clk);
      crystal_clock <= ~crystal_clock;
   end

   // hang guard: the full run needs about 1140 cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         bad_count = bad_count + 1;
         stop_test;
      end
   end

   task stop_test;
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // idle cycle after each access so a strobe is never assigned twice in one step
   task wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task rd(input logic [3:0] a, input logic [7:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 check("reg_rdata", reg_rdata, exp);
      @(posedge sys_clk);
   endtask

   // apply one setting, let two carrier rises pass, then judge both drivers
   task cfg(input logic [7:0] c, input logic env);
      logic       fa, fb, mb;
      logic [7:0] e0, e1;
      fa = c[7] && !env;
      fb = fa && !c[2];
      mb = !env && !c[2];
      wr(4'h0, c);
      tx_envelope <= env;
      repeat (40) @(posedge sys_clk);
      #1;
      e0 = edges_a;
      e1 = edges_b;
      check("pmos_a", {2'b00, pmos_a}, c[0] ? (env ? 8'h15 : 8'h0a) : 8'h00);
      check("nmos_a", {4'h0, nmos_a}, c[0] ? (env ? 8'h0c : 8'h03) : 8'h00);
      check("pmos_b", {2'b00, pmos_b}, c[1] ? (mb ? 8'h0a : 8'h15) : 8'h00);
      check("nmos_b", {4'h0, nmos_b}, c[1] ? (mb ? 8'h03 : 8'h0c) : 8'h00);
      @(posedge carrier);
      // status read is taken one edge after the rise, so the carrier bit reads high
      rd(4'h4, {3'h0, !env && !c[2] && c[1], !env && c[0], c[1], c[0], 1'b1});
      repeat (2) @(posedge sys_clk);
      #1;
      if (c[0]) check("pin_a", {7'h00, pin_a}, {7'h00, !fa && (carrier ^ c[4])});
      if (c[1]) check("pin_b", {7'h00, pin_b}, {7'h00, !fb && (carrier ^ c[6])});
      repeat (20) @(posedge sys_clk);
      #1;
      if (c[0]) check("toggle_a", {7'h00, edges_a != e0}, {7'h00, !fa});
      if (c[1]) check("toggle_b", {7'h00, edges_b != e1}, {7'h00, !fb});
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(4'h0, 8'h00);
      rd(4'h1, 8'h3f);
      rd(4'h2, 8'h20);
      rd(4'h3, 8'h88);
      rd(4'h9, 8'h00);
      wr(4'h1, 8'hd5);
      wr(4'h2, 8'h4a);
      wr(4'h3, 8'hc3);
      rd(4'h1, 8'h15);
      rd(4'h2, 8'h0a);
      rd(4'h3, 8'hc3);
      foreach (cfgs[i]) begin
         cfg(cfgs[i], 1'b0);
         cfg(cfgs[i], 1'b1);
      end
      stop_test;
   end
endmodule
